// *** core/cfg_link_if.sv ***
`timescale 1ns/1ps
interface cfg_link_if;
    logic config_request_n;
    logic config_clock;
    logic config_data;
    logic user_startup_clock;
    logic dev_status_o;
    logic dev_status_oe_n;
    logic host_status_o;
    logic host_status_oe_n;
    logic status_n;
    logic conf_done;

    // open-drain status line with pull-up
    assign status_n = (dev_status_oe_n | dev_status_o) & (host_status_oe_n | host_status_o);

    modport device (
        input config_request_n, config_clock, config_data, user_startup_clock, status_n,
        output dev_status_o, dev_status_oe_n, conf_done
    );
    modport host (
        output config_request_n, config_clock, config_data, user_startup_clock,
        output host_status_o, host_status_oe_n,
        input status_n, conf_done
    );
endinterface : cfg_link_if

// *** core/cfg_seq_device.sv ***
`timescale 1ns/1ps
`include "cfg_seq_regs.svh"
module cfg_seq_device
    import cfg_seq_pkg::*;
#(
    parameter int WORD_W = 8,
    parameter int CFG_WORDS = 16,
    parameter int STATUS_MIN_CYC = `STATUS_MIN_CYC,
    parameter int INIT_OSC_CYC = `CD2UM_MIN_CYC,
    parameter int INIT_CLOCKS = `INIT_CLOCKS,
    parameter int WDT_OSC_CYCLES = 65536
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // configuration link
    cfg_link_if.device link,
    // user side
    input wire init_src_e i_init_src,
    input wire logic i_reconfig,
    input wire logic i_wdt_en,
    input wire logic i_wdt_kick,
    input wire logic i_word_ready,
    output logic [WORD_W-1:0] o_word,
    output logic o_word_valid,
    output logic o_user_mode,
    output logic o_error
);
    // ----------------------------------------------------------------
    // sizes and checks
    // ----------------------------------------------------------------
    localparam int CW = 18;
    localparam int BW = $clog2(WORD_W + 1);
    localparam int TW = $clog2(CFG_WORDS + 1);
    // timeout is counted for the fastest oscillator, so it never runs long
    localparam longint WDT_CYC_L = (longint'(WDT_OSC_CYCLES) * `CLK_MHZ * 1000) / `OSC_MAX_KHZ;
    localparam logic [31:0] WDT_CYC = WDT_CYC_L[31:0];
    localparam logic [CW-1:0] ST_MIN = CW'(STATUS_MIN_CYC);
    localparam logic [CW-1:0] OSC_CYC = CW'(INIT_OSC_CYC);
    localparam logic [CW-1:0] CU_CYC = CW'(`CD2CU_CYC);
    localparam logic [CW-1:0] INIT_CLK = CW'(INIT_CLOCKS);
    localparam logic [5:0] STB_CYC = 6'(`STROBE_CYC);
    localparam logic [BW-1:0] WORD_BITS = BW'(WORD_W);
    localparam logic [TW-1:0] WORDS = TW'(CFG_WORDS);

    initial begin
        if (WORD_W < 1 || CFG_WORDS < 1 || STATUS_MIN_CYC < 1 || INIT_OSC_CYC < 1)
            $error("cfg_seq_device: bad size parameter");
        if (STATUS_MIN_CYC >= (1 << CW) || INIT_OSC_CYC >= (1 << CW) || INIT_CLOCKS >= (1 << CW))
            $error("cfg_seq_device: count exceeds counter width");
        if (`REQ2LOW_CYC < 3)
            $error("cfg_seq_device: request-to-low budget below sync latency");
        if (STATUS_MIN_CYC > `STATUS_MAX_CYC)
            $error("cfg_seq_device: status low time above its maximum");
        if (INIT_OSC_CYC > `CD2UM_MAX_CYC)
            $error("cfg_seq_device: oscillator init above its maximum");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        dev_state_e state;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [1:0] s3;
        logic [CW-1:0] cnt;
        logic [CW-1:0] ecnt;
        logic [WORD_W-1:0] shift;
        logic [BW-1:0] nbits;
        logic [TW-1:0] nwords;
        logic [WORD_W-1:0] word;
        logic word_vld;
        logic status_low;
        logic done;
        logic user;
        logic err;
        logic [5:0] rcfg_cnt;
        logic [5:0] kick_cnt;
        logic [31:0] wdt_cnt;
    } dev_s;

    dev_s r;
    dev_s r_nxt;
    logic cclk_rise;
    logic uclk_rise;
    logic rcfg_hit;
    logic kick_hit;
    logic wdt_expire;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_nxt = r;
        // sync order: request, status, config clock, data, startup clock
        r_nxt.s1 = {link.user_startup_clock, link.config_data, link.config_clock,
                    link.status_n, link.config_request_n};
        r_nxt.s2 = r.s1;
        r_nxt.s3 = {r.s2[4], r.s2[2]};
        cclk_rise = r.s2[2] & ~r.s3[0];
        uclk_rise = r.s2[4] & ~r.s3[1];
        if (i_word_ready) begin
            r_nxt.word_vld = 1'b0;
        end
        // strobes take effect once, after being high long enough
        r_nxt.rcfg_cnt = (i_reconfig && r.rcfg_cnt != STB_CYC) ? r.rcfg_cnt + 6'h01 :
                         (i_reconfig ? r.rcfg_cnt : 6'h00);
        r_nxt.kick_cnt = (i_wdt_kick && r.kick_cnt != STB_CYC) ? r.kick_cnt + 6'h01 :
                         (i_wdt_kick ? r.kick_cnt : 6'h00);
        rcfg_hit = i_reconfig && (r.rcfg_cnt == STB_CYC - 6'h01);
        kick_hit = i_wdt_kick && (r.kick_cnt == STB_CYC - 6'h01);
        wdt_expire = 1'b0;
        case (r.state)
            DEV_RESET: begin
                if (r.cnt != ST_MIN) begin
                    r_nxt.cnt = r.cnt + CW'(1);
                end else begin
                    r_nxt.status_low = 1'b0;
                    r_nxt.state = DEV_WAIT_REL;
                end
            end
            DEV_WAIT_REL: begin
                // status may be held low from outside
                if (r.s2[1]) begin
                    r_nxt.state = DEV_LOAD;
                    r_nxt.nbits = '0;
                    r_nxt.nwords = '0;
                end
            end
            DEV_LOAD: begin
                if (cclk_rise) begin
                    r_nxt.shift = {r.s2[3], r.shift[WORD_W-1:1]};
                    r_nxt.nbits = r.nbits + BW'(1);
                    if (r.nbits == WORD_BITS - BW'(1)) begin
                        r_nxt.nbits = '0;
                        r_nxt.nwords = r.nwords + TW'(1);
                        r_nxt.word = {r.s2[3], r.shift[WORD_W-1:1]};
                        r_nxt.word_vld = 1'b1;
                        if (r.word_vld && !i_word_ready) begin
                            // consumer too slow: flag it on the status line
                            r_nxt.state = DEV_ERROR;
                            r_nxt.status_low = 1'b1;
                            r_nxt.err = 1'b1;
                        end else if (r.nwords == WORDS - TW'(1)) begin
                            r_nxt.done = 1'b1;
                            r_nxt.state = DEV_INIT;
                            r_nxt.cnt = '0;
                            r_nxt.ecnt = '0;
                        end
                    end
                end
            end
            DEV_INIT: begin
                case (i_init_src)
                    INIT_OSC: begin
                        r_nxt.cnt = r.cnt + CW'(1);
                        if (r.cnt == OSC_CYC - CW'(1)) begin
                            r_nxt.state = DEV_USER;
                        end
                    end
                    INIT_USR: begin
                        // startup clock ignored until 4 config clock periods passed
                        if (r.cnt != CU_CYC) begin
                            r_nxt.cnt = r.cnt + CW'(1);
                        end else if (uclk_rise) begin
                            r_nxt.ecnt = r.ecnt + CW'(1);
                            if (r.ecnt == INIT_CLK - CW'(1)) begin
                                r_nxt.state = DEV_USER;
                            end
                        end
                    end
                    default: begin
                        if (cclk_rise) begin
                            r_nxt.ecnt = r.ecnt + CW'(1);
                            if (r.ecnt == INIT_CLK - CW'(1)) begin
                                r_nxt.state = DEV_USER;
                            end
                        end
                    end
                endcase
                r_nxt.wdt_cnt = '0;
            end
            DEV_USER: begin
                r_nxt.user = 1'b1;
                if (!i_wdt_en || kick_hit) begin
                    r_nxt.wdt_cnt = '0;
                end else begin
                    r_nxt.wdt_cnt = r.wdt_cnt + 32'h1;
                    wdt_expire = (r.wdt_cnt == WDT_CYC - 32'h1);
                end
            end
            default: begin
                r_nxt.status_low = 1'b1;
            end
        endcase
        // request low, reconfigure or watchdog restart the whole sequence
        if (!r.s2[0] || rcfg_hit || wdt_expire) begin
            r_nxt.state = DEV_RESET;
            r_nxt.status_low = 1'b1;
            r_nxt.done = 1'b0;
            r_nxt.user = 1'b0;
            r_nxt.cnt = '0;
            r_nxt.err = 1'b0;
            r_nxt.word_vld = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r <= '0;
            r.state <= DEV_RESET;
            r.status_low <= `DEV_STATUS_LOW_RST;
            r.done <= `DEV_DONE_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.dev_status_o = 1'b0;
    assign link.dev_status_oe_n = ~r.status_low;
    assign link.conf_done = r.done;
    assign o_word = r.word;
    assign o_word_valid = r.word_vld;
    assign o_user_mode = r.user;
    assign o_error = r.err;
endmodule : cfg_seq_device

// *** core/cfg_seq_host.sv ***
`timescale 1ns/1ps
`include "cfg_seq_regs.svh"
module cfg_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // fill side
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // drain side
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("cfg_word_fifo: depth must be a power of two >= 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_s;
    fifo_s r;
    fifo_s r_nxt;
    logic full;
    logic empty;

    always_comb begin
        r_nxt = r;
        full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
        empty = (r.wp == r.rp);
        if (i_valid && !full) begin
            r_nxt.mem[r.wp[AW-1:0]] = i_data;
            r_nxt.wp = r.wp + (AW+1)'(1);
        end
        if (i_ready && !empty) begin
            r_nxt.rp = r.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign o_data = r.mem[r.rp[AW-1:0]];
endmodule : cfg_word_fifo

module cfg_seq_host
    import cfg_seq_pkg::*;
#(
    parameter int WORD_W = 8,
    parameter int FIFO_DEPTH = 16,
    parameter int CLK_HALF = 10,
    parameter int CF2CK_CYC = `CF2CK_CYC,
    parameter int INIT_CLOCKS = `INIT_CLOCKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // configuration link
    cfg_link_if.host link,
    // control
    input wire logic i_start,
    input wire logic i_monitor,
    input wire logic i_init_cclk,
    input wire logic i_usr_clk_en,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    // configuration words
    input wire logic [WORD_W-1:0] i_word,
    input wire logic i_word_valid,
    output logic o_word_ready
);
    localparam int CW = 18;
    localparam int BW = $clog2(WORD_W + 1);
    localparam logic [7:0] HALF = 8'(CLK_HALF);
    localparam logic [CW-1:0] REQ_CYC = CW'(`REQ_LOW_CYC);
    localparam logic [CW-1:0] CK_CYC = CW'(CF2CK_CYC);
    localparam logic [CW-1:0] ST_CYC = CW'(`ST2CK_CYC);
    localparam logic [CW-1:0] INIT_CLK = CW'(INIT_CLOCKS);
    initial begin
        // half period must keep the clock at or below its maximum rate
        if (CLK_HALF < 1 || CLK_HALF > 255 || 2 * CLK_HALF * `CFG_CLK_MAX_MHZ < `CLK_MHZ)
            $error("cfg_seq_host: bad clock divider");
        if (CF2CK_CYC >= (1 << CW) || INIT_CLOCKS >= (1 << CW) || CF2CK_CYC < 1)
            $error("cfg_seq_host: count exceeds counter width");
    end

    typedef struct packed {
        host_state_e state;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [CW-1:0] cnt;
        logic [7:0] div;
        logic [7:0] udiv;
        logic cclk;
        logic uclk;
        logic req_n;
        logic [WORD_W-1:0] shift;
        logic [BW-1:0] nbits;
        logic done;
        logic err;
    } host_s;
    host_s r;
    host_s r_nxt;
    logic [WORD_W-1:0] f_data;
    logic f_valid;
    logic f_pop;
    logic tick;

    cfg_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_data(i_word),
        .i_valid(i_word_valid),
        .o_ready(o_word_ready),
        .o_data(f_data),
        .o_valid(f_valid),
        .i_ready(f_pop)
    );

    always_comb begin
        r_nxt = r;
        f_pop = 1'b0;
        // sync order: status, done
        r_nxt.s1 = {link.conf_done, link.status_n};
        r_nxt.s2 = r.s1;
        tick = (r.div == HALF - 8'h01);
        r_nxt.div = tick ? 8'h00 : r.div + 8'h01;
        // free-running startup clock, well under its 125 MHz limit
        r_nxt.udiv = (r.udiv == HALF - 8'h01) ? 8'h00 : r.udiv + 8'h01;
        if (r.udiv == HALF - 8'h01) begin
            r_nxt.uclk = i_usr_clk_en & ~r.uclk;
        end
        case (r.state)
            HOST_REQ: begin
                r_nxt.cnt = r.cnt + CW'(1);
                if (r.cnt == REQ_CYC - CW'(1)) begin
                    r_nxt.req_n = 1'b1;
                    r_nxt.cnt = '0;
                    r_nxt.state = HOST_WAIT;
                end
            end
            HOST_WAIT: begin
                if (i_monitor && !r.s2[0]) begin
                    r_nxt.cnt = '0;
                end else begin
                    r_nxt.cnt = r.cnt + CW'(1);
                    if (r.cnt == (i_monitor ? ST_CYC : CK_CYC) - CW'(1)) begin
                        r_nxt.state = HOST_SEND;
                    end
                end
            end
            HOST_SEND: begin
                if (tick && r.cclk) begin
                    r_nxt.cclk = 1'b0;
                    r_nxt.shift = r.shift >> 1;
                    r_nxt.nbits = r.nbits - BW'(1);
                end else if (tick && r.nbits != '0) begin
                    r_nxt.cclk = 1'b1;
                end else if (!r.cclk && r.nbits == '0 && f_valid) begin
                    // load only while the clock is low, so data is set up before the rise
                    f_pop = 1'b1;
                    r_nxt.shift = f_data;
                    r_nxt.nbits = BW'(WORD_W);
                end
                if (r.s2[1] && !r.cclk) begin
                    r_nxt.cnt = '0;
                    r_nxt.state = i_init_cclk ? HOST_INIT : HOST_DONE;
                end else if (!r.s2[0]) begin
                    r_nxt.err = 1'b1;
                    r_nxt.state = HOST_IDLE;
                end
            end
            HOST_INIT: begin
                // config clock keeps running to initialize the device
                if (tick) begin
                    r_nxt.cclk = ~r.cclk;
                    if (!r.cclk) begin
                        r_nxt.cnt = r.cnt + CW'(1);
                        if (r.cnt == INIT_CLK - CW'(1)) begin
                            r_nxt.state = HOST_DONE;
                        end
                    end
                end
            end
            HOST_DONE: begin
                r_nxt.cclk = 1'b0;
                r_nxt.done = 1'b1;
            end
            default: begin
                r_nxt.cclk = 1'b0;
            end
        endcase
        if (i_start) begin
            r_nxt.state = HOST_REQ;
            r_nxt.req_n = 1'b0;
            r_nxt.cnt = '0;
            r_nxt.cclk = 1'b0;
            r_nxt.nbits = '0;
            r_nxt.done = 1'b0;
            r_nxt.err = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r <= '0;
            r.state <= HOST_IDLE;
            r.req_n <= `HOST_REQ_N_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign link.config_request_n = r.req_n;
    assign link.config_clock = r.cclk;
    assign link.config_data = r.shift[0];
    assign link.user_startup_clock = r.uclk;
    assign link.host_status_o = 1'b0;
    assign link.host_status_oe_n = 1'b1;
    assign o_busy = (r.state != HOST_IDLE) && (r.state != HOST_DONE);
    assign o_done = r.done;
    assign o_error = r.err;
endmodule : cfg_seq_host

// *** core/cfg_seq_pkg.sv ***
package cfg_seq_pkg;
    typedef enum logic [2:0] {
        DEV_RESET = 3'b000,
        DEV_WAIT_REL = 3'b001,
        DEV_LOAD = 3'b010,
        DEV_INIT = 3'b011,
        DEV_USER = 3'b100,
        DEV_ERROR = 3'b101
    } dev_state_e;

    typedef enum logic [1:0] {
        INIT_OSC = 2'b00,
        INIT_USR = 2'b01,
        INIT_CCLK = 2'b10
    } init_src_e;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_REQ = 3'b001,
        HOST_WAIT = 3'b010,
        HOST_SEND = 3'b011,
        HOST_INIT = 3'b100,
        HOST_DONE = 3'b101
    } host_state_e;
endpackage : cfg_seq_pkg

// *** core/cfg_seq_regs.svh ***
`ifndef CFG_SEQ_REGS_SVH
`define CFG_SEQ_REGS_SVH
// Summary of operation
// - request low drops done within 600 ns
// - request low drops status within 600 ns
// - host holds request low at least 2 us
// - status stays low 268 to 1506 us
// - status released within 1506 us after request
// - unmonitored host waits 1506 us before clocking
// - monitoring host waits 2 us after status
// - oscillator init reaches user mode 175-437 us
// - startup clock after 4 periods, 8576 cycles
// - host supplies 8576 config init clocks, max 125 MHz
// - oscillator, startup clock or config clock init
// - reconfigure and watchdog strobes last 250 ns
// - watchdog timeout tolerates 5.3-12.5 MHz oscillator

// ----------------------------------------------------------------
// clock and timing figures
// ----------------------------------------------------------------
`define CLK_MHZ 125
`define T_REQ2LOW_NS 600
`define T_REQ_LOW_US 2
`define T_STATUS_MIN_US 268
`define T_STATUS_MAX_US 1506
`define T_CF2CK_US 1506
`define T_ST2CK_US 2
`define T_CD2UM_MIN_US 175
`define T_CD2UM_MAX_US 437
`define T_STROBE_NS 250
`define CD2CU_PERIODS 4
`define CFG_CLK_MAX_MHZ 125
`define INIT_CLOCKS 8576
`define OSC_MIN_KHZ 5300
`define OSC_TYP_KHZ 7900
`define OSC_MAX_KHZ 12500

// ----------------------------------------------------------------
// derived cycle counts (least times round up, longest round down)
// ----------------------------------------------------------------
`define REQ2LOW_CYC ((`T_REQ2LOW_NS * `CLK_MHZ) / 1000)
`define REQ_LOW_CYC (`T_REQ_LOW_US * `CLK_MHZ)
`define STATUS_MIN_CYC (`T_STATUS_MIN_US * `CLK_MHZ)
`define STATUS_MAX_CYC (`T_STATUS_MAX_US * `CLK_MHZ)
`define CF2CK_CYC (`T_CF2CK_US * `CLK_MHZ)
`define ST2CK_CYC (`T_ST2CK_US * `CLK_MHZ)
`define CD2UM_MIN_CYC (`T_CD2UM_MIN_US * `CLK_MHZ)
`define CD2UM_MAX_CYC (`T_CD2UM_MAX_US * `CLK_MHZ)
`define STROBE_CYC ((`T_STROBE_NS * `CLK_MHZ + 999) / 1000)
`define CD2CU_CYC ((`CD2CU_PERIODS * `CLK_MHZ + `CFG_CLK_MAX_MHZ - 1) / `CFG_CLK_MAX_MHZ)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DEV_DONE_RST 1'b0
`define DEV_STATUS_LOW_RST 1'b1
`define HOST_REQ_N_RST 1'b1
`endif

// *** verif/cfg_seq_monitor.sv ***
`timescale 1ns/1ps
module cfg_seq_monitor #(
    parameter int WORD_W = 8,
    parameter int CFG_WORDS = 16,
    parameter int STATUS_MIN_CYC = 40,
    parameter int CF2CK_CYC = 60
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic config_request_n,
    input wire logic config_clock,
    input wire logic status_n,
    input wire logic conf_done
);
    localparam int REL_MAX = STATUS_MIN_CYC + 8;
    logic [15:0] req_low_r, st_low_r, since_req_r, bits_r;
    logic clk_q_r, clocked_r;
    // ----
    // low-time and edge counters
    // ----
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            req_low_r <= 16'h0000;
            st_low_r <= 16'h0000;
            since_req_r <= 16'h0000;
            bits_r <= 16'h0000;
            clk_q_r <= 1'b0;
            clocked_r <= 1'b0;
        end else begin
            req_low_r <= config_request_n ? 16'h0000 : req_low_r + 16'h0001;
            st_low_r <= status_n ? 16'h0000 : st_low_r + 16'h0001;
            since_req_r <= config_request_n ? since_req_r + 16'h0001 : 16'h0000;
            bits_r <= config_request_n ? bits_r + {15'h0000, config_clock & ~clk_q_r} : 16'h0000;
            clk_q_r <= config_clock;
            clocked_r <= config_request_n & (clocked_r | config_clock);
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    sequence s_pulled;
        ##[1:75] !status_n;
    endsequence
    sequence s_released;
        ##[1:REL_MAX] status_n;
    endsequence
    property p_done_drop;
        $fell(config_request_n) |-> ##[1:75] !conf_done;
    endproperty
    property p_status_drop;
        $fell(config_request_n) |-> s_pulled;
    endproperty
    property p_req_width;
        $rose(config_request_n) |-> req_low_r >= 16'd250;
    endproperty
    property p_status_min;
        $rose(status_n) |-> st_low_r >= STATUS_MIN_CYC;
    endproperty
    property p_status_rel;
        $rose(config_request_n) |-> s_released;
    endproperty
    property p_first_clk;
        $rose(config_clock) && !clocked_r |-> since_req_r >= CF2CK_CYC;
    endproperty
    property p_clk_status;
        $rose(config_clock) |-> status_n && $past(status_n, 8);
    endproperty
    property p_bits_done;
        $rose(conf_done) |-> bits_r == WORD_W * CFG_WORDS;
    endproperty
    a_done_drop: assert property (p_done_drop) else $error("done not dropped");
    a_status_drop: assert property (p_status_drop) else $error("status not pulled");
    a_req_width: assert property (p_req_width) else $error("request too short");
    a_status_min: assert property (p_status_min) else $error("status low too short");
    a_status_rel: assert property (p_status_rel) else $error("status not released");
    a_first_clk: assert property (p_first_clk) else $error("first clock too early");
    a_clk_status: assert property (p_clk_status) else $error("clock near status low");
    a_bits_done: assert property (p_bits_done) else $error("done at wrong bit count");
endmodule : cfg_seq_monitor

// *** verif/tb_passive_serial_config_sequencer.sv ***
`timescale 1ns/1ps
module tb_passive_serial_config_sequencer;
    import cfg_seq_pkg::*;
    logic i_clk, i_nrst, start, mon, icclk, usren, reconfig, wrdy, wval, hrdy, dval, umode;
    logic hdone, herr, derr, pu, pc, wen, kick, busy;
    logic [7:0] wdata, dword;
    logic [31:0] rnd;
    init_src_e src;
    int n_fail, comparisons, ecnt, t;
    logic [7:0] expq[$];
    localparam int SM = 40, CK = 60, NI = 16, NO = 20;
    cfg_link_if lk();
    cfg_seq_host #(.CF2CK_CYC(CK), .INIT_CLOCKS(NI)) i_cfg_seq_host (.i_clk(i_clk),
        .i_nrst(i_nrst), .link(lk), .i_start(start), .i_monitor(mon), .i_init_cclk(icclk),
        .i_usr_clk_en(usren), .o_busy(busy), .o_done(hdone), .o_error(herr), .i_word(wdata),
        .i_word_valid(wval), .o_word_ready(hrdy));
    cfg_seq_device #(.STATUS_MIN_CYC(SM), .INIT_OSC_CYC(NO), .INIT_CLOCKS(NI),
        .WDT_OSC_CYCLES(NO)) i_cfg_seq_device (.i_clk(i_clk), .i_nrst(i_nrst), .link(lk),
        .i_init_src(src), .i_reconfig(reconfig), .i_wdt_en(wen), .i_wdt_kick(kick),
        .i_word_ready(wrdy), .o_word(dword), .o_word_valid(dval), .o_user_mode(umode),
        .o_error(derr));
    cfg_seq_monitor #(.STATUS_MIN_CYC(SM), .CF2CK_CYC(CK)) i_cfg_seq_monitor (
        .i_clk(i_clk), .i_nrst(i_nrst), .config_request_n(lk.config_request_n),
        .config_clock(lk.config_clock), .status_n(lk.status_n), .conf_done(lk.conf_done));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // oscillator counts cycles, the others count clock rises
    function automatic int exp_init(input init_src_e s);
        return (s == INIT_OSC) ? NO : NI;
    endfunction : exp_init
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task end_sim;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
    always @(negedge i_clk) begin
        if (lk.conf_done !== 1'b1) ecnt = 0;
        else if (umode !== 1'b1) ecnt += (src == INIT_OSC) ? 1 : (src == INIT_USR) ?
            int'(lk.user_startup_clock & !pu) : int'(lk.config_clock & !pc);
        pu = lk.user_startup_clock;
        pc = lk.config_clock;
    end
    // random stalls of the word sink; the transfer lands at the next rise
    always @(negedge i_clk) begin
        rnd = xs(rnd);
        if (dval === 1'b1 && rnd[3]) begin
            chk("word", expq.size() > 0 ? expq[0] : 8'hxx, dword);
            if (expq.size() > 0) void'(expq.pop_front());
        end
        wrdy <= rnd[3];
    end
    // ----
    // main sequence
    // ----
    initial begin
        {i_nrst, start, mon, icclk, usren, reconfig, wrdy, wval, wen, kick} = 10'h002;
        wdata = 8'h00;
        rnd = 32'h0000004e;
        src = INIT_OSC;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk) i_nrst = 1'b1;
        for (int r = 0; r < 3; r++) begin
            src = init_src_e'(r[1:0]);
            mon = r[0];
            icclk = (r == 2);
            usren = (r == 1);
            // the 17th offer meets a full buffer and must be refused
            for (int k = 0; k < 17; k++) begin
                @(negedge i_clk);
                wdata = (k == 0) ? 8'h00 : (k == 15) ? 8'hff : rnd[15:8];
                wval = 1'b1;
                if (k < 16) expq.push_back(wdata);
            end
            chk("fifo_ready", 8'h00, {7'h00, hrdy});
            @(negedge i_clk) {wval, start} = 2'b01;
            @(negedge i_clk) start = 1'b0;
            for (t = 0; t < 100 && umode !== 1'b0; t++) @(negedge i_clk);
            for (t = 0; t < 20000 && umode !== 1'b1; t++) @(negedge i_clk);
            chk("user_mode", 8'h01, {7'h00, umode});
            chk("init_span", 8'h01, {7'h00, ecnt >= exp_init(src) && ecnt <= exp_init(src) + 4});
            chk("done_err", 8'h02, {5'h00, busy, hdone, derr | herr});
            chk("drained", 8'h00, 8'(expq.size()));
        end
        repeat (150) @(negedge i_clk);
        kick = 1'b1;
        repeat (60) @(negedge i_clk);
        chk("wdt_kick", 8'h01, {7'h00, lk.status_n});
        repeat (200) @(negedge i_clk);
        chk("wdt_fire", 8'h00, {7'h00, lk.status_n});
        @(negedge i_clk) reconfig = 1'b1;
        repeat (20) @(negedge i_clk);
        reconfig = 1'b0;
        repeat (10) @(negedge i_clk);
        chk("short_strobe", 8'h01, {7'h00, lk.status_n});
        reconfig = 1'b1;
        repeat (40) @(negedge i_clk);
        reconfig = 1'b0;
        repeat (8) @(negedge i_clk);
        chk("reconfig", 8'h00, {7'h00, lk.status_n});
        end_sim();
    end
endmodule : tb_passive_serial_config_sequencer
